// ===== fgcs_pkg.sv
// Package with constants and carrier types for the frame grab command and status bank.
`default_nettype none
package fgcs_pkg;
    // Number of camera channels: primary and secondary connector.
    localparam int unsigned NUM_CH = 2;
    // Register indices; the byte address is four times the index.
    localparam logic [5:0] IDX_CMD_REV = 6'h00;
    localparam logic [5:0] IDX_STATUS = 6'h01;
    localparam logic [5:0] IDX_CONTROL = 6'h02;
    localparam logic [5:0] IDX_IRQ_STATUS = 6'h0B;
    // Index step between the primary and secondary register sets.
    localparam logic [7:0] IDX_SECONDARY_STEP = 8'h40;
    // Byte address fields: index in [7:2], channel in [8], upper bits must be zero.
    localparam int unsigned ADDR_IDX_LSB = 2;
    localparam int unsigned ADDR_IDX_MSB = 7;
    localparam int unsigned ADDR_CH_BIT = 8;
    localparam int unsigned ADDR_TOP_LSB = 9;
    // Command bit positions.
    localparam int unsigned CMD_INTERFACE_RESET = 0;
    localparam int unsigned CMD_ARM = 1;
    localparam int unsigned CMD_CLEAR_CAPTURE_IRQ = 2;
    localparam int unsigned CMD_STOP_REPEAT = 3;
    localparam int unsigned CMD_CLEAR_FV_IRQ = 4;
    // Status bit positions.
    localparam int unsigned ST_OVERRUN = 0;
    localparam int unsigned ST_FRAME_VALID = 1;
    localparam int unsigned ST_EXPOSURE = 2;
    localparam int unsigned ST_TRIGGER_ARMED = 3;
    localparam int unsigned ST_OPTO_TRIG = 4;
    localparam int unsigned ST_CABLE_TRIG = 5;
    localparam int unsigned ST_GRAB_ARMED = 6;
    localparam int unsigned ST_CAPTURE_IP = 7;
    // Control register fields.
    localparam int unsigned CTL_HW_TRIGGER_MODE_LSB = 0;
    localparam int unsigned CTL_HW_TRIGGER_MODE_MSB = 2;
    localparam int unsigned CTL_FV_EDGE = 3;
    localparam int unsigned CTL_REARM = 4;
    localparam int unsigned CTL_CAPTURE_IRQ_EN = 7;
    localparam logic [7:0] CTL_WRITE_MASK = 8'h9F;
    localparam logic [7:0] CTL_RESET = 8'h00;
    // Interrupt status fields.
    localparam int unsigned IRQ_FV = 4;
    localparam int unsigned IRQ_CAPTURE = 5;
    // Revision nibble; the value is arbitrary.
    localparam logic [3:0] REVISION_LEVEL = 4'h1;
    // AHB transfer type bit that marks an active transfer.
    localparam int unsigned HTRANS_ACTIVE_BIT = 1;
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    // Acquisition sequencer states.
    typedef enum logic [1:0] {
        ACQ_IDLE = 2'b00,
        ACQ_TRIG_WAIT = 2'b01,
        ACQ_ARMED = 2'b10,
        ACQ_CAPTURE = 2'b11
    } fgcs_acq_e;

    // Signals from one camera and its data path.
    typedef struct packed {
        logic frame_valid;
        logic opto_trig;
        logic cable_trig;
        logic pixel_valid;
        logic host_ready;
    } fgcs_cam_in_s;

    // Signals towards one camera and its data path.
    typedef struct packed {
        logic expose;
        logic capture_en;
        logic dma_abort;
    } fgcs_cam_out_s;
endpackage
`default_nettype wire

// ===== fgcs_top.sv
// Command, revision and status register bank with acquisition control, two channels.
// Contract
// - Command bits are pulses, never stored, except bit 3 written outside capture, held pending until capture start.
// - Reading command offset returns revision register.
// - Command bit 4 clears frame-valid flag.
// - Bit 3 clears repeat mode at capture.
// - Command bit 2 clears capture flag.
// - Command bit 1 arms acquisition.
// - Armed capture starts on frame-valid rise.
// - Leave armed at capture unless repeating.
// - Bit 0 resets interface, flags, DMA.
// - Revision in low nibble, upper zero.
// - Status bit 7 shows capture in progress.
// - Status bit 6 shows waiting for frame.
// - Status bit 5 shows cable trigger level.
// - Status bit 4 shows opto trigger level.
// - Status bit 3 shows waiting for trigger.
// - Trigger wait clears at capture unless mode bit2.
// - Status bit 2 shows expose line.
// - Status bit 1 mirrors frame-valid always.
// - Status bit 0 flags lost frame data.
// - Secondary set decoded at index plus 0x40.
// - Capture flag on capture start when enabled.
// - Frame-valid flag edge chosen by select bit.
`default_nettype none

// One camera channel: acquisition sequencer, flags and status byte.
module fgcs_channel
    import fgcs_pkg::*;
(
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [7:0] cmd_i,
    input wire logic ctl_we_i,
    input wire logic [7:0] ctl_wdata_i,
    input wire fgcs_cam_in_s cam_i,
    output fgcs_cam_out_s cam_o,
    output logic [7:0] status_o,
    output logic [7:0] control_o,
    output logic [7:0] irq_status_o
);
    fgcs_acq_e state_q, state_d;
    logic [7:0] ctl_q, ctl_d;
    logic trig_armed_q, trig_armed_d;
    logic expose_q, expose_d;
    logic stop_pending_q, stop_pending_d;
    logic capture_irq_q, capture_irq_d;
    logic fv_irq_q, fv_irq_d;
    logic overrun_q, overrun_d;
    logic fv_prev_q;
    logic abort_q, abort_d;
    logic fv_rise;
    logic fv_fall;
    logic trig_hit;
    logic capture_start;
    logic [2:0] hw_mode;

    assign fv_rise = cam_i.frame_valid & ~fv_prev_q;
    assign fv_fall = ~cam_i.frame_valid & fv_prev_q;
    assign hw_mode = ctl_q[CTL_HW_TRIGGER_MODE_MSB:CTL_HW_TRIGGER_MODE_LSB];
    // Mode bits 0 and 1 pick the opto and cable inputs as hardware trigger sources.
    assign trig_hit = (hw_mode[0] & cam_i.opto_trig) | (hw_mode[1] & cam_i.cable_trig);
    assign capture_start = (state_q == ACQ_ARMED) && fv_rise;

    // Sequencer, control and flag next values; interface reset overrides all but the control register.
    always_comb begin
        state_d = state_q;
        ctl_d = ctl_q;
        trig_armed_d = trig_armed_q;
        expose_d = expose_q;
        stop_pending_d = stop_pending_q;
        capture_irq_d = capture_irq_q;
        fv_irq_d = fv_irq_q;
        overrun_d = overrun_q;
        abort_d = 1'b0;
        if (ctl_we_i) begin
            ctl_d = ctl_wdata_i & CTL_WRITE_MASK;
        end
        unique case (state_q)
            ACQ_IDLE: begin
                if (cmd_i[CMD_ARM]) begin
                    if (hw_mode[1:0] != 2'b00) begin
                        state_d = ACQ_TRIG_WAIT;
                    end else begin
                        state_d = ACQ_ARMED;
                    end
                end
            end
            ACQ_TRIG_WAIT: begin
                // The trigger fires the expose line and moves on to wait for a frame.
                if (trig_hit) begin
                    state_d = ACQ_ARMED;
                    expose_d = 1'b1;
                end
            end
            ACQ_ARMED: begin
                if (capture_start) begin
                    state_d = ACQ_CAPTURE;
                end
            end
            ACQ_CAPTURE: begin
                if (fv_fall) begin
                    if (!ctl_d[CTL_REARM]) begin
                        state_d = ACQ_IDLE;
                    end else if (hw_mode[1:0] != 2'b00 && !trig_armed_q) begin
                        state_d = ACQ_TRIG_WAIT;
                    end else begin
                        state_d = ACQ_ARMED;
                    end
                end
            end
        endcase
        if (cmd_i[CMD_ARM] && hw_mode[1:0] != 2'b00) begin
            trig_armed_d = 1'b1;
        end
        if (state_q == ACQ_CAPTURE && fv_fall && ctl_d[CTL_REARM] && hw_mode[1:0] != 2'b00) begin
            trig_armed_d = 1'b1;
        end
        if (capture_start && !hw_mode[2]) begin
            trig_armed_d = 1'b0;
        end
        // The expose line stays on until the camera answers with a frame.
        if (fv_rise) begin
            expose_d = 1'b0;
        end
        if (cmd_i[CMD_STOP_REPEAT] && state_q == ACQ_CAPTURE) begin
            ctl_d[CTL_REARM] = 1'b0;
        end else if (cmd_i[CMD_STOP_REPEAT]) begin
            stop_pending_d = 1'b1;
        end
        if (capture_start && (stop_pending_q || cmd_i[CMD_STOP_REPEAT])) begin
            ctl_d[CTL_REARM] = 1'b0;
            stop_pending_d = 1'b0;
        end
        if (cmd_i[CMD_CLEAR_CAPTURE_IRQ]) begin
            capture_irq_d = 1'b0;
        end
        if (capture_start && ctl_q[CTL_CAPTURE_IRQ_EN]) begin
            capture_irq_d = 1'b1;
        end
        if (cmd_i[CMD_CLEAR_FV_IRQ]) begin
            fv_irq_d = 1'b0;
        end
        if (ctl_q[CTL_FV_EDGE] ? fv_rise : fv_fall) begin
            fv_irq_d = 1'b1;
        end
        if (state_q == ACQ_CAPTURE && cam_i.pixel_valid && !cam_i.host_ready) begin
            overrun_d = 1'b1;
        end
        if (cmd_i[CMD_INTERFACE_RESET]) begin
            state_d = ACQ_IDLE;
            trig_armed_d = 1'b0;
            expose_d = 1'b0;
            stop_pending_d = 1'b0;
            capture_irq_d = 1'b0;
            fv_irq_d = 1'b0;
            overrun_d = 1'b0;
            abort_d = 1'b1;
        end
    end

    // Channel state registers.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_q <= ACQ_IDLE;
            ctl_q <= CTL_RESET;
            trig_armed_q <= 1'b0;
            expose_q <= 1'b0;
            stop_pending_q <= 1'b0;
            capture_irq_q <= 1'b0;
            fv_irq_q <= 1'b0;
            overrun_q <= 1'b0;
            fv_prev_q <= 1'b0;
            abort_q <= 1'b0;
        end else begin
            state_q <= state_d;
            ctl_q <= ctl_d;
            trig_armed_q <= trig_armed_d;
            expose_q <= expose_d;
            stop_pending_q <= stop_pending_d;
            capture_irq_q <= capture_irq_d;
            fv_irq_q <= fv_irq_d;
            overrun_q <= overrun_d;
            fv_prev_q <= cam_i.frame_valid;
            abort_q <= abort_d;
        end
    end

    // Status byte assembly; trigger levels and frame-valid are shown live.
    always_comb begin
        status_o = 8'h00;
        status_o[ST_CAPTURE_IP] = (state_q == ACQ_CAPTURE);
        status_o[ST_GRAB_ARMED] = (state_q == ACQ_ARMED) ||
            (state_q == ACQ_CAPTURE && ctl_q[CTL_REARM]);
        status_o[ST_CABLE_TRIG] = cam_i.cable_trig;
        status_o[ST_OPTO_TRIG] = cam_i.opto_trig;
        status_o[ST_TRIGGER_ARMED] = trig_armed_q;
        status_o[ST_EXPOSURE] = expose_q;
        status_o[ST_FRAME_VALID] = cam_i.frame_valid;
        status_o[ST_OVERRUN] = overrun_q;
    end

    // Flag register view and camera-side outputs.
    always_comb begin
        irq_status_o = 8'h00;
        irq_status_o[IRQ_CAPTURE] = capture_irq_q;
        irq_status_o[IRQ_FV] = fv_irq_q;
        control_o = ctl_q;
        cam_o.expose = expose_q;
        cam_o.capture_en = (state_q == ACQ_CAPTURE);
        cam_o.dma_abort = abort_q;
    end
endmodule

// AHB-Lite slave with a zero-wait answer and one register set per channel.
module fgcs_top
    import fgcs_pkg::*;
(
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    input wire fgcs_cam_in_s [NUM_CH-1:0] cam_i,
    output fgcs_cam_out_s [NUM_CH-1:0] cam_o
);
    logic wr_pend_q, wr_pend_d;
    logic [5:0] wr_idx_q, wr_idx_d;
    logic wr_ch_q, wr_ch_d;
    logic [31:0] rdata_q, rdata_d;
    logic access;
    logic mapped;
    logic [5:0] a_idx;
    logic a_ch;
    logic [7:0] status [NUM_CH];
    logic [7:0] control [NUM_CH];
    logic [7:0] irq_status [NUM_CH];
    logic [7:0] cmd [NUM_CH];
    logic ctl_we [NUM_CH];

    // Address phase decode; odd sizes are treated like word transfers.
    assign access = hsel_i && htrans_i[HTRANS_ACTIVE_BIT] && hready_i;
    assign a_idx = haddr_i[ADDR_IDX_MSB:ADDR_IDX_LSB];
    // secondary set one index step up
    assign a_ch = haddr_i[ADDR_CH_BIT];
    assign mapped = (haddr_i[31:ADDR_TOP_LSB] == 23'h00_0000) &&
        (haddr_i[ADDR_IDX_LSB-1:0] == 2'b00);

    // Capture writes for the data phase and prepare read data one cycle early.
    always_comb begin
        wr_pend_d = 1'b0;
        wr_idx_d = wr_idx_q;
        wr_ch_d = wr_ch_q;
        rdata_d = 32'h0000_0000;
        if (access && mapped) begin
            wr_pend_d = hwrite_i;
            wr_idx_d = a_idx;
            wr_ch_d = a_ch;
            if (!hwrite_i) begin
                unique case (a_idx)
                    IDX_CMD_REV: begin
                        rdata_d = {28'h000_0000, REVISION_LEVEL};
                    end
                    IDX_STATUS: begin
                        rdata_d = {24'h00_0000, status[a_ch]};
                    end
                    IDX_CONTROL: begin
                        rdata_d = {24'h00_0000, control[a_ch]};
                    end
                    IDX_IRQ_STATUS: begin
                        rdata_d = {24'h00_0000, irq_status[a_ch]};
                    end
                    default: begin
                        rdata_d = 32'h0000_0000;
                    end
                endcase
            end
        end
    end

    // Bus state registers.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wr_pend_q <= 1'b0;
            wr_idx_q <= 6'h00;
            wr_ch_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            wr_pend_q <= wr_pend_d;
            wr_idx_q <= wr_idx_d;
            wr_ch_q <= wr_ch_d;
            rdata_q <= rdata_d;
        end
    end

    // The slave never stalls and never signals an error.
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;
    assign hrdata_o = rdata_q;

    // One channel per connector; write strobes live only for the data phase cycle.
    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
        assign cmd[c] = (wr_pend_q && wr_ch_q == 1'(c) && wr_idx_q == IDX_CMD_REV) ?
            hwdata_i[7:0] : 8'h00;
        assign ctl_we[c] = wr_pend_q && wr_ch_q == 1'(c) && wr_idx_q == IDX_CONTROL;
        fgcs_channel u_channel (
            .clk_i(clk_i),
            .resetn_i(resetn_i),
            .cmd_i(cmd[c]),
            .ctl_we_i(ctl_we[c]),
            .ctl_wdata_i(hwdata_i[7:0]),
            .cam_i(cam_i[c]),
            .cam_o(cam_o[c]),
            .status_o(status[c]),
            .control_o(control[c]),
            .irq_status_o(irq_status[c])
        );
    end
endmodule
`default_nettype wire

// ===== fgcs_checker.sv
// Checker of bus answers and acquisition timing at the bank's ports.
`default_nettype none
module fgcs_checker
    import fgcs_pkg::*;
(
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    input wire logic [31:0] hrdata_o,
    input wire fgcs_cam_in_s [NUM_CH-1:0] cam_i,
    input wire fgcs_cam_out_s [NUM_CH-1:0] cam_o
);
    logic ap, rd_st, cmd_d, cmd_q, rst_cmd;
    // Address-phase decode; a command write is remembered until its data phase.
    always_comb begin
        ap = hsel_i && htrans_i[HTRANS_ACTIVE_BIT] && hready_i;
        rd_st = ap && !hwrite_i && haddr_i == 32'h4;
        cmd_d = ap && hwrite_i && haddr_i == '0;
        rst_cmd = cmd_q && hwdata_i[CMD_INTERFACE_RESET];
    end
    // The command data only exists one cycle after its address.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cmd_q <= 1'b0;
        end else begin
            cmd_q <= cmd_d;
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    a_rev_read: assert property (ap && !hwrite_i && haddr_i == '0 |=>
        hrdata_o == 32'(REVISION_LEVEL)) else $error("revision read wrong");
    a_trig_levels: assert property (rd_st &&
        $stable({cam_i[0].cable_trig, cam_i[0].opto_trig})
        |=> hrdata_o[5:4] == $past({cam_i[0].cable_trig, cam_i[0].opto_trig}))
        else $error("trigger level bits wrong");
    a_fv_mirror: assert property (rd_st && $stable(cam_i[0].frame_valid) |=>
        hrdata_o[1] == $past(cam_i[0].frame_valid)) else $error("frame valid bit wrong");
    a_state_bits: assert property (rd_st |=> hrdata_o[7] == $past(cam_o[0].capture_en)
        && hrdata_o[2] == $past(cam_o[0].expose)) else $error("capture or expose bit wrong");
    a_capture_start: assert property ($rose(cam_o[0].capture_en) |->
        $past(cam_i[0].frame_valid) && !$past(cam_i[0].frame_valid, 2))
        else $error("capture began without a frame start");
    a_capture_end: assert property ($fell(cam_i[0].frame_valid) |=>
        !cam_o[0].capture_en) else $error("capture outlived the frame");
    a_abort_pulse: assert property (rst_cmd |=> cam_o[0].dma_abort ##1
        !cam_o[0].dma_abort) else $error("abort pulse wrong");
    a_abort_cause: assert property ($rose(cam_o[0].dma_abort) |->
        $past(rst_cmd)) else $error("abort without a reset command");
endmodule
bind fgcs_top fgcs_checker u_chk (.clk_i(clk_i), .resetn_i(resetn_i), .hsel_i(hsel_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hwdata_i(hwdata_i),
    .hready_i(hready_i), .hrdata_o(hrdata_o), .cam_i(cam_i), .cam_o(cam_o));
`default_nettype wire

// ===== fgcs_cam_model.sv
// Behavioural camera that sends a frame on request or on an expose rise.
`default_nettype none
module fgcs_cam_model
    import fgcs_pkg::*;
#(
    parameter int FLEN = 12
)(
    input wire logic clk_i,
    input wire logic go_i,
    input wire logic stall_i,
    input wire logic opto_i,
    input wire logic cable_i,
    input wire fgcs_cam_out_s cam_i,
    output fgcs_cam_in_s cam_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;
    logic exp_q = 1'b0;
    logic fv = 1'b0;
    logic pv = 1'b0;
    // Frame valid rises six cycles after the request, so a trigger can be read first.
    always @(posedge clk_i) begin
        exp_q <= cam_i.expose;
        if (cnt != 0) begin
            cnt <= (cnt == FLEN + 6) ? 0 : cnt + 1;
        end else if (go_i || (cam_i.expose && !exp_q)) begin
            cnt <= 1;
        end
        fv <= cnt >= 6 && cnt < FLEN + 6;
        pv <= cnt >= 6 && cnt < FLEN + 6 && !pv;
    end
    // Pixels are qualified only inside the frame; the stall stands for a full host.
    assign cam_o = {fv, opto_i, cable_i, pv, !stall_i};
endmodule
`default_nettype wire

// ===== tb.sv
// Self-checking bench for the frame grab command and status bank.
`default_nettype none
module tb import fgcs_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic hsel = 1'b0, hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
    logic [2:0] hsize = HSIZE_WORD;
    logic [1:0] go = 2'h0, stall = 2'h0, opto = 2'h0, cable = 2'h0;
    logic hready, hresp;
    fgcs_cam_in_s [NUM_CH-1:0] cam_i;
    fgcs_cam_out_s [NUM_CH-1:0] cam_o;
    int fail_count = 0, samples_checked = 0;
    // Free running system clock.
    always #5 clk_i = ~clk_i;
    fgcs_top dut (.clk_i(clk_i), .resetn_i(resetn_i), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
        .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
        .cam_i(cam_i), .cam_o(cam_o));
    // One camera per channel.
    for (genvar c = 0; c < NUM_CH; c++) begin : g_cam
        fgcs_cam_model m (.clk_i(clk_i), .go_i(go[c]), .stall_i(stall[c]),
            .opto_i(opto[c]), .cable_i(cable[c]), .cam_i(cam_o[c]), .cam_o(cam_i[c]));
    end
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", n, exp, seen);
        end
    endtask
    // Single transfer; the master waits on hready, never on a fixed count.
    task automatic xfer(input logic w, input logic [31:0] a, input logic [7:0] wd);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge clk_i); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h00_0000, wd};
        do @(posedge clk_i); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task automatic wr(input logic [31:0] a, input logic [7:0] d);
        xfer(1'b1, a, d);
    endtask
    task automatic rdc(input string n, input logic [31:0] a, input logic [7:0] e);
        xfer(1'b0, a, 8'h00);
        chk(n, rd, {24'h00_0000, e});
        chk("hresp", {31'h0, hresp}, 32'h0);
    endtask
    // Expected status: the model's state bits plus the live camera levels.
    task automatic st(input int c, input logic [7:0] e);
        rdc("status", 32'(c * 256 + 4), e | {2'b0, cable[c], opto[c], 2'b0,
            cam_i[c].frame_valid, 1'b0});
    endtask
    task automatic fvw(input int c, input logic v);
        for (int i = 0; i < 100 && cam_i[c].frame_valid !== v; i++) @(posedge clk_i);
        repeat (2) @(posedge clk_i);
    endtask
    task automatic shot(input int c);
        go[c] <= 1'b1;
        @(posedge clk_i);
        go[c] <= 1'b0;
        fvw(c, 1'b1);
    endtask
    // Opto trigger held long enough to be seen, then dropped before the read.
    task automatic trig(input int c);
        opto[c] <= 1'b1;
        repeat (3) @(posedge clk_i);
        opto[c] <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask
    // Hang guard, far beyond the few hundred cycles the tests need.
    initial begin
        repeat (20000) @(posedge clk_i);
        fail_count++;
        give_verdict();
    end
    // Main sequence.
    initial begin
        void'($urandom(30));
        repeat (10) @(posedge clk_i);
        resetn_i <= 1'b1;
        @(posedge clk_i);
        rdc("control", 32'h8, CTL_RESET);
        rdc("revision", 32'h0, {4'h0, REVISION_LEVEL});
        rdc("revision1", 32'h100, {4'h0, REVISION_LEVEL});
        wr(32'h4, 8'hFF);
        st(0, 8'h00);
        rdc("unmapped", 32'h3C, 8'h00);
        rdc("outside", 32'h200, 8'h00);
        wr(32'h8, 8'h80);
        shot(0);
        st(0, 8'h00);
        wr(32'h0, 8'h02);
        st(0, 8'h40);
        fvw(0, 1'b0);
        rdc("flags", 32'h2C, 8'h10);
        shot(0);
        st(0, 8'h80);
        fvw(0, 1'b0);
        st(0, 8'h00);
        rdc("flags", 32'h2C, 8'h30);
        wr(32'h0, 8'h04);
        rdc("flags", 32'h2C, 8'h10);
        wr(32'h0, 8'h10);
        rdc("flags", 32'h2C, 8'h00);
        wr(32'h8, 8'h08);
        shot(0);
        rdc("flags", 32'h2C, 8'h10);
        fvw(0, 1'b0);
        wr(32'h8, 8'h90);
        wr(32'h0, 8'h02);
        shot(0);
        st(0, 8'hC0);
        fvw(0, 1'b0);
        st(0, 8'h40);
        shot(0);
        wr(32'h0, 8'h08);
        rdc("control", 32'h8, 8'h80);
        fvw(0, 1'b0);
        wr(32'h0, 8'h01);
        wr(32'h8, 8'h90);
        wr(32'h0, 8'h02);
        wr(32'h0, 8'h08);
        rdc("control", 32'h8, 8'h90);
        shot(0);
        rdc("control", 32'h8, 8'h80);
        fvw(0, 1'b0);
        wr(32'h0, 8'h01);
        wr(32'h8, 8'h01);
        wr(32'h0, 8'h02);
        st(0, 8'h08);
        trig(0);
        st(0, 8'h4C);
        fvw(0, 1'b1);
        st(0, 8'h80);
        fvw(0, 1'b0);
        wr(32'h8, 8'h05);
        wr(32'h0, 8'h02);
        trig(0);
        fvw(0, 1'b1);
        st(0, 8'h88);
        fvw(0, 1'b0);
        wr(32'h0, 8'h01);
        wr(32'h8, 8'h80);
        wr(32'h0, 8'h02);
        stall[0] <= 1'b1;
        shot(0);
        fvw(0, 1'b0);
        stall[0] <= 1'b0;
        st(0, 8'h01);
        wr(32'h0, 8'h01);
        st(0, 8'h00);
        rdc("flags", 32'h2C, 8'h00);
        for (int i = 0; i < 6; i++) begin
            opto <= 2'($urandom);
            cable <= 2'($urandom);
            repeat (2) @(posedge clk_i);
            st(0, 8'h00);
            st(1, 8'h00);
        end
        opto <= 2'h0;
        cable <= 2'h0;
        wr(32'h100, 8'h02);
        st(0, 8'h00);
        shot(1);
        st(1, 8'h80);
        fvw(1, 1'b0);
        give_verdict();
    end
endmodule
`default_nettype wire
